// file: shared/fbled_regs.svh
`ifndef FBLED_REGS_SVH
`define FBLED_REGS_SVH

// ==========================================================================
// Clock and time base
// ==========================================================================
`define FBLED_CLK_HZ        25000000
`define FBLED_UNIT_MS       50
`define FBLED_UNIT_CYC      ((`FBLED_CLK_HZ / 1000) * `FBLED_UNIT_MS)
`define FBLED_DIV_W         21
`define FBLED_PH_W          5
`define FBLED_TU_W          3

// ==========================================================================
// Pattern intervals, in ms and in time-base units
// ==========================================================================
`define FBLED_FLASH_MS      200
`define FBLED_FLASH_U       (`FBLED_FLASH_MS / `FBLED_UNIT_MS)
`define FBLED_LONG_OFF_MS   1000
`define FBLED_LONG_OFF_U    (`FBLED_LONG_OFF_MS / `FBLED_UNIT_MS)
`define FBLED_SLOW_MS       500
`define FBLED_SLOW_U        (`FBLED_SLOW_MS / `FBLED_UNIT_MS)
`define FBLED_TEST_MS       250
`define FBLED_TEST_U        (`FBLED_TEST_MS / `FBLED_UNIT_MS)

// ==========================================================================
// Slave state codes from the protocol stack
// ==========================================================================
`define FBLED_SLV_INIT      2'h0
`define FBLED_SLV_PREOP     2'h1
`define FBLED_SLV_SAFEOP    2'h2
`define FBLED_SLV_OP        2'h3

// ==========================================================================
// Error codes shown on err_code_o
// ==========================================================================
`define FBLED_ERR_NONE      2'h0
`define FBLED_ERR_CFG       2'h1
`define FBLED_ERR_LOCAL     2'h2
`define FBLED_ERR_WDOG      2'h3

`endif

// file: shared/fbled_pkg.sv
`include "fbled_regs.svh"

package fbled_pkg;

    // Lamp waveform selection
    typedef enum logic [2:0] {
        PAT_OFF,
        PAT_ON,
        PAT_BLINK,
        PAT_SINGLE,
        PAT_DOUBLE,
        PAT_SLOW
    } fbled_pat_t;

    // Power-up self-test sequence
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MS_G,
        ST_MS_R,
        ST_NS_G,
        ST_NS_R,
        ST_HOLD
    } fbled_st_state_t;

    typedef struct packed {
        fbled_pat_t                pat;
        logic [`FBLED_DIV_W-1:0]   div;
        logic [`FBLED_PH_W-1:0]    phase;
        logic                      lamp;
    } fbled_pat_st_t;

    typedef struct packed {
        fbled_st_state_t           state;
        logic [`FBLED_DIV_W-1:0]   div;
        logic [`FBLED_TU_W-1:0]    units;
        logic                      active;
        logic                      ms_g;
        logic                      ms_r;
        logic                      ns_g;
        logic                      ns_r;
    } fbled_st_st_t;

    typedef struct packed {
        logic                      sync_forced;
        logic [1:0]                last_state;
        logic [1:0]                eff_state;
        logic [1:0]                err_code;
        logic                      ms_red_sel;
        logic                      ns_red_sel;
        logic                      ms_g;
        logic                      ms_r;
        logic                      ns_g;
        logic                      ns_r;
        logic                      test_active;
    } fbled_top_st_t;

endpackage

// file: core/fbled_pattern.sv
`timescale 1ns/1ps
`include "fbled_regs.svh"

module fbled_pattern #(
    parameter int unsigned UNIT_CYC = `FBLED_UNIT_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  ce_i,
    input  wire fbled_pkg::fbled_pat_t pat_i,
    output logic                       lamp_o
);

    localparam logic [`FBLED_PH_W-1:0] F  = `FBLED_PH_W'(`FBLED_FLASH_U);
    localparam logic [`FBLED_PH_W-1:0] L  = `FBLED_PH_W'(`FBLED_LONG_OFF_U);
    localparam logic [`FBLED_PH_W-1:0] S  = `FBLED_PH_W'(`FBLED_SLOW_U);
    localparam logic [`FBLED_DIV_W-1:0] DIV_LAST =
        `FBLED_DIV_W'(UNIT_CYC - 1);

    fbled_pkg::fbled_pat_st_t s_ff;
    fbled_pkg::fbled_pat_st_t nxt_s;

    // ======================================================================
    // Waveform decode
    // ======================================================================
    function automatic logic [`FBLED_PH_W-1:0] last_phase(
        input fbled_pkg::fbled_pat_t p);
        case (p)
            fbled_pkg::PAT_BLINK:  last_phase = F + F - 1'b1;
            fbled_pkg::PAT_SINGLE: last_phase = F + L - 1'b1;
            fbled_pkg::PAT_DOUBLE:
                last_phase = F + F + F + L - 1'b1;
            fbled_pkg::PAT_SLOW:   last_phase = S + S - 1'b1;
            default:               last_phase = '0;
        endcase
    endfunction

    function automatic logic lamp_on(input fbled_pkg::fbled_pat_t p,
                                     input logic [`FBLED_PH_W-1:0] ph);
        case (p)
            fbled_pkg::PAT_ON:     lamp_on = 1'b1;
            fbled_pkg::PAT_BLINK,
            fbled_pkg::PAT_SINGLE: lamp_on = (ph < F);
            fbled_pkg::PAT_DOUBLE: lamp_on = (ph < F) ||
                                     (ph >= F + F && ph < F + F + F);
            fbled_pkg::PAT_SLOW:   lamp_on = (ph < S);
            default:               lamp_on = 1'b0;
        endcase
    endfunction

    // ======================================================================
    // Phase stepping, restarted on any change of selection
    // ======================================================================
    always_comb begin
        nxt_s = s_ff;
        if (pat_i != s_ff.pat) begin
            nxt_s.pat   = pat_i;
            nxt_s.div   = '0;
            nxt_s.phase = '0;
        end else if (s_ff.div == DIV_LAST) begin
            nxt_s.div   = '0;
            nxt_s.phase = (s_ff.phase == last_phase(s_ff.pat)) ? '0
                        : s_ff.phase + 1'b1;
        end else begin
            nxt_s.div   = s_ff.div + 1'b1;
        end
        nxt_s.lamp = lamp_on(nxt_s.pat, nxt_s.phase);
    end

    // Frozen while the enable is low
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_ff <= '{pat: fbled_pkg::PAT_OFF, default: '0};
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign lamp_o = s_ff.lamp;

endmodule

// file: core/fbled_selftest.sv
`timescale 1ns/1ps
`include "fbled_regs.svh"

module fbled_selftest #(
    parameter int unsigned UNIT_CYC = `FBLED_UNIT_CYC
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    input  wire logic busy_i,
    output logic      active_o,
    output logic      ms_g_o,
    output logic      ms_r_o,
    output logic      ns_g_o,
    output logic      ns_r_o
);

    localparam logic [`FBLED_TU_W-1:0] STEP_LAST =
        `FBLED_TU_W'(`FBLED_TEST_U - 1);
    localparam logic [`FBLED_DIV_W-1:0] DIV_LAST =
        `FBLED_DIV_W'(UNIT_CYC - 1);

    fbled_pkg::fbled_st_st_t s_ff;
    fbled_pkg::fbled_st_st_t nxt_s;
    logic                    step_done;

    // ======================================================================
    // Sequencer: module lamp first, network lamp only afterwards
    // ======================================================================
    always_comb begin
        nxt_s     = s_ff;
        step_done = (s_ff.div == DIV_LAST) && (s_ff.units == STEP_LAST);
        if (s_ff.div == DIV_LAST) begin
            nxt_s.div   = '0;
            nxt_s.units = step_done ? '0 : s_ff.units + 1'b1;
        end else begin
            nxt_s.div   = s_ff.div + 1'b1;
        end
        case (s_ff.state)
            fbled_pkg::ST_IDLE: begin
                nxt_s.div   = '0;
                nxt_s.units = '0;
                if (busy_i) begin
                    nxt_s.state = fbled_pkg::ST_MS_G;
                end
            end
            fbled_pkg::ST_MS_G: if (step_done) begin
                nxt_s.state = fbled_pkg::ST_MS_R;
            end
            fbled_pkg::ST_MS_R: if (step_done) begin
                nxt_s.state = fbled_pkg::ST_NS_G;
            end
            fbled_pkg::ST_NS_G: if (step_done) begin
                nxt_s.state = fbled_pkg::ST_NS_R;
            end
            fbled_pkg::ST_NS_R: if (step_done) begin
                nxt_s.state = fbled_pkg::ST_HOLD;
            end
            default: ;
        endcase
        // Test end releases both lamps at once
        if (!busy_i) begin
            nxt_s.state = fbled_pkg::ST_IDLE;
        end
        nxt_s.active = (nxt_s.state != fbled_pkg::ST_IDLE);
        nxt_s.ms_r   = (nxt_s.state == fbled_pkg::ST_MS_R);
        nxt_s.ms_g   = nxt_s.active && !nxt_s.ms_r;
        nxt_s.ns_g   = (nxt_s.state == fbled_pkg::ST_NS_G);
        nxt_s.ns_r   = (nxt_s.state == fbled_pkg::ST_NS_R);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_ff <= '{state: fbled_pkg::ST_IDLE, default: '0};
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign active_o = s_ff.active;
    assign ms_g_o   = s_ff.ms_g;
    assign ms_r_o   = s_ff.ms_r;
    assign ns_g_o   = s_ff.ns_g;
    assign ns_r_o   = s_ff.ns_r;

endmodule

// file: core/fbled_top.sv
`timescale 1ns/1ps
`include "fbled_regs.svh"


module fbled_top #(
    parameter int unsigned UNIT_CYC = `FBLED_UNIT_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       ce_i,
    input  wire logic       mode_cip_i,
    input  wire logic [1:0] slave_state_i,
    input  wire logic       err_invalid_cfg_i,
    input  wire logic       err_local_i,
    input  wire logic       err_sync_i,
    input  wire logic       err_app_wdog_i,
    input  wire logic       cip_configured_i,
    input  wire logic       cip_fault_rec_i,
    input  wire logic       cip_fault_unrec_i,
    input  wire logic       selftest_busy_i,
    output logic            module_status_lamp_green_o,
    output logic            module_status_lamp_red_o,
    output logic            network_status_lamp_green_o,
    output logic            network_status_lamp_red_o,
    output logic [1:0]      eff_state_o,
    output logic [1:0]      err_code_o,
    output logic            selftest_active_o
);

    // ======================================================================
    // Declarations
    // ======================================================================
    fbled_pkg::fbled_top_st_t s_ff;
    fbled_pkg::fbled_top_st_t nxt_s;

    fbled_pkg::fbled_pat_t    ms_pat;
    fbled_pkg::fbled_pat_t    ns_pat;
    logic                     ms_red_req;
    logic                     ns_red_req;
    logic                     ms_lamp;
    logic                     ns_lamp;
    logic                     st_active;
    logic                     st_ms_g;
    logic                     st_ms_r;
    logic                     st_ns_g;
    logic                     st_ns_r;
    logic                     local_err;
    logic                     sync_drop;
    logic                     forced;
    logic [1:0]               eff_state;
    logic [1:0]               err_code;
    logic                     cip_test;

    // ======================================================================
    // Decode helpers
    // ======================================================================

    // Green run-state waveform per slave state
    function automatic fbled_pkg::fbled_pat_t run_pattern(
        input logic [1:0] st);
        case (st)
            `FBLED_SLV_INIT:   run_pattern = fbled_pkg::PAT_OFF;
            `FBLED_SLV_PREOP:  run_pattern = fbled_pkg::PAT_BLINK;
            `FBLED_SLV_SAFEOP: run_pattern = fbled_pkg::PAT_SINGLE;
            `FBLED_SLV_OP:     run_pattern = fbled_pkg::PAT_ON;
            default:           run_pattern = fbled_pkg::PAT_OFF;
        endcase
    endfunction

    // Red error waveform per error code
    function automatic fbled_pkg::fbled_pat_t err_pattern(
        input logic [1:0] code);
        case (code)
            `FBLED_ERR_CFG:   err_pattern = fbled_pkg::PAT_BLINK;
            `FBLED_ERR_LOCAL: err_pattern = fbled_pkg::PAT_SINGLE;
            `FBLED_ERR_WDOG:  err_pattern = fbled_pkg::PAT_DOUBLE;
            default:          err_pattern = fbled_pkg::PAT_OFF;
        endcase
    endfunction

    // Severity ranking when errors overlap
    function automatic logic [1:0] worst_error(input logic wdog,
                                               input logic local_e,
                                               input logic cfg);
        if (wdog) begin
            worst_error = `FBLED_ERR_WDOG;
        end else if (local_e) begin
            worst_error = `FBLED_ERR_LOCAL;
        end else if (cfg) begin
            worst_error = `FBLED_ERR_CFG;
        end else begin
            worst_error = `FBLED_ERR_NONE;
        end
    endfunction

    // ======================================================================
    // Slave state handling
    // ======================================================================

    // A sync error only pulls an operational slave back; lower states
    // already sit at or below safe-operational, so nothing is forced there.
    // The forced state lasts until the stack reports a new state, which is
    // how a later master command shows up at this block.
    // A held drop is let go in the very cycle the state moves, so a stale
    // safe-op never flashes onto the newly reported state.
    assign sync_drop = !mode_cip_i && err_sync_i
                     && (slave_state_i == `FBLED_SLV_OP);
    assign forced    = sync_drop || (s_ff.sync_forced && !mode_cip_i
                     && (slave_state_i == s_ff.last_state));
    assign eff_state = forced ? `FBLED_SLV_SAFEOP : slave_state_i;

    // Forced drop is autonomous, so it ranks as a local error
    assign local_err = err_local_i || forced;

    assign err_code = worst_error(err_app_wdog_i, local_err,
                                  err_invalid_cfg_i);

    // ======================================================================
    // Pattern and colour selection
    // ======================================================================

    // Self-test only belongs to the CIP bus
    assign cip_test = mode_cip_i && st_active;

    // Module lamp: CIP faults ranked unrecoverable first
    always_comb begin
        ms_pat     = fbled_pkg::PAT_OFF;
        ms_red_req = 1'b0;
        if (mode_cip_i) begin
            if (cip_fault_unrec_i) begin
                ms_pat     = fbled_pkg::PAT_ON;
                ms_red_req = 1'b1;
            end else if (cip_fault_rec_i) begin
                ms_pat     = fbled_pkg::PAT_SLOW;
                ms_red_req = 1'b1;
            end else if (!cip_configured_i) begin
                ms_pat     = fbled_pkg::PAT_SLOW;
            end else begin
                ms_pat     = fbled_pkg::PAT_ON;
            end
        end else begin
            ms_pat = run_pattern(eff_state);
        end
    end

    // Network lamp: red error side on the slave bus, dark on CIP here
    always_comb begin
        ns_red_req = 1'b1;
        if (mode_cip_i) begin
            ns_pat = fbled_pkg::PAT_OFF;
        end else begin
            ns_pat = err_pattern(err_code);
        end
    end

    // ======================================================================
    // Waveform generators and self-test sequencer
    // ======================================================================

    // Each generator keeps its own divider so a restart is exact to the
    // cycle, at the cost of two counters instead of one shared tick.
    fbled_pattern #(
        .UNIT_CYC (UNIT_CYC)
    ) u_ms_pat (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .pat_i  (ms_pat),
        .lamp_o (ms_lamp)
    );

    fbled_pattern #(
        .UNIT_CYC (UNIT_CYC)
    ) u_ns_pat (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .pat_i  (ns_pat),
        .lamp_o (ns_lamp)
    );

    fbled_selftest #(
        .UNIT_CYC (UNIT_CYC)
    ) u_selftest (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .ce_i     (ce_i),
        .busy_i   (selftest_busy_i && mode_cip_i),
        .active_o (st_active),
        .ms_g_o   (st_ms_g),
        .ms_r_o   (st_ms_r),
        .ns_g_o   (st_ns_g),
        .ns_r_o   (st_ns_r)
    );

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        nxt_s            = s_ff;
        nxt_s.last_state = slave_state_i;

        // New reported state clears the forced drop; a sync error in the
        // same cycle still wins so the event is never lost.
        if (slave_state_i != s_ff.last_state) begin
            nxt_s.sync_forced = 1'b0;
        end
        if (!mode_cip_i && err_sync_i &&
            (slave_state_i == `FBLED_SLV_OP)) begin
            nxt_s.sync_forced = 1'b1;
        end
        if (mode_cip_i) begin
            nxt_s.sync_forced = 1'b0;
        end

        // Colour is delayed one cycle to line up with the generator flop
        nxt_s.ms_red_sel = ms_red_req;
        nxt_s.ns_red_sel = ns_red_req;

        // Lamp drive; self-test owns both lamps while it runs
        if (cip_test) begin
            nxt_s.ms_g = st_ms_g;
            nxt_s.ms_r = st_ms_r;
            nxt_s.ns_g = st_ns_g;
            nxt_s.ns_r = st_ns_r;
        end else begin
            nxt_s.ms_g = ms_lamp && !s_ff.ms_red_sel;
            nxt_s.ms_r = ms_lamp && s_ff.ms_red_sel;
            nxt_s.ns_g = ns_lamp && !s_ff.ns_red_sel;
            nxt_s.ns_r = ns_lamp && s_ff.ns_red_sel;
        end

        nxt_s.eff_state   = eff_state;
        nxt_s.err_code    = mode_cip_i ? `FBLED_ERR_NONE : err_code;
        nxt_s.test_active = cip_test;
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_ff <= '0;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    // ======================================================================
    // Outputs, all straight from the state register
    // ======================================================================
    assign module_status_lamp_green_o  = s_ff.ms_g;
    assign module_status_lamp_red_o    = s_ff.ms_r;
    assign network_status_lamp_green_o = s_ff.ns_g;
    assign network_status_lamp_red_o   = s_ff.ns_r;
    assign eff_state_o                 = s_ff.eff_state;
    assign err_code_o                  = s_ff.err_code;
    assign selftest_active_o           = s_ff.test_active;

endmodule

// file: tb/fbled_lamp_meter.sv
`timescale 1ns/1ps
// ========================================
// Lamp model: measures on and off runs
module fbled_lamp_meter (
    input  wire logic       clk_i,
    input  wire logic       lamp_i,
    output logic [7:0]      on_len_o,
    output logic [7:0]      off_len_o,
    output logic [7:0]      rises_o
);
    logic       prev_ff = 1'b0;
    logic [7:0] run_ff  = 8'h00;
    logic [7:0] on_ff   = 8'h00;
    logic [7:0] off_ff  = 8'h00;
    logic [7:0] rise_ff = 8'h00;
    // Run is booked when the lamp flips; runs over 255 wrap
    always @(posedge clk_i) begin
        prev_ff <= lamp_i;
        if (lamp_i === prev_ff) begin
            run_ff <= run_ff + 8'h01;
        end else begin
            run_ff <= 8'h01;
            if (lamp_i === 1'b1) begin
                off_ff  <= run_ff;
                rise_ff <= rise_ff + 8'h01;
            end else begin
                on_ff <= run_ff;
            end
        end
    end
    // Outputs
    assign on_len_o  = on_ff;
    assign off_len_o = off_ff;
    assign rises_o   = rise_ff;
endmodule

// file: tb/fbled_top_assertions.sv
`timescale 1ns/1ps
// ========================================
// Lamp and status checks
module fbled_top_assertions #(
    parameter int unsigned UNIT_CYC = 4
) (
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic       mode_cip_i,
    input wire logic [1:0] slave_state_i,
    input wire logic       err_invalid_cfg_i,
    input wire logic       err_local_i,
    input wire logic       err_sync_i,
    input wire logic       err_app_wdog_i,
    input wire logic       module_status_lamp_green_o,
    input wire logic       network_status_lamp_green_o,
    input wire logic       network_status_lamp_red_o,
    input wire logic [1:0] eff_state_o,
    input wire logic [1:0] err_code_o,
    input wire logic       selftest_active_o
);
    localparam int ON_N  = 4 * UNIT_CYC;
    localparam int ON_M1 = 4 * UNIT_CYC - 1;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Blink on-run, or the selection left in the meantime
    sequence s_on_run;
        ##ON_M1 module_status_lamp_green_o ##1 !module_status_lamp_green_o;
    endsequence
    sequence s_left;
        ##[0:ON_N] (slave_state_i != 2'h1 || mode_cip_i);
    endsequence
    chk_init_dark: assert property (
        (!mode_cip_i && slave_state_i == 2'h0)[*3]
        |=> !module_status_lamp_green_o) else $error("green lit in init");
    chk_op_steady: assert property (
        (!mode_cip_i && eff_state_o == 2'h3)[*3]
        |=> module_status_lamp_green_o) else $error("green dark in op");
    chk_no_err: assert property (
        (!mode_cip_i && err_code_o == 2'h0)[*3]
        |=> !network_status_lamp_red_o) else $error("red lit, no error");
    chk_sync_force: assert property (
        !mode_cip_i && slave_state_i == 2'h3 && err_sync_i
        |=> eff_state_o == 2'h2 && err_code_o[1]) else $error("sync lost");
    chk_wdog_rank: assert property (
        !mode_cip_i && err_app_wdog_i
        |=> err_code_o == 2'h3) else $error("watchdog code wrong");
    chk_local_rank: assert property (
        !mode_cip_i && !err_app_wdog_i && err_local_i
        |=> err_code_o == 2'h2) else $error("local code wrong");
    chk_cfg_code: assert property (
        !mode_cip_i && !err_app_wdog_i && !err_local_i
        && slave_state_i != 2'h3 && err_invalid_cfg_i
        |=> err_code_o == 2'h1) else $error("config code wrong");
    chk_blink_run: assert property (
        $rose(module_status_lamp_green_o) && $past(eff_state_o) == 2'h1
        && !mode_cip_i |-> s_on_run or s_left) else $error("blink length");
    chk_test_dark: assert property (
        $rose(selftest_active_o) |-> (!network_status_lamp_green_o
        && !network_status_lamp_red_o)[*8]) else $error("net lamp early");
endmodule

bind fbled_top fbled_top_assertions #(.UNIT_CYC(UNIT_CYC)) i_chk (.*);

// file: tb/fbled_top_tb.sv
`timescale 1ns/1ps
// ========================================
// Bench for the lamp pattern block
module fbled_top_tb;
    logic       clk_i  = 1'b0;
    logic       srst_i = 1'b1;
    logic       cip    = 1'b0;
    logic [1:0] st     = 2'h0;
    logic       cfg    = 1'b0, loc = 1'b0, syn = 1'b0, wd = 1'b0;
    logic       conf   = 1'b1, rec = 1'b0, unr = 1'b0, bsy = 1'b0;
    logic       mg, mr, ng, nr, tact;
    logic [1:0] eff, code;
    logic [7:0] a_on, a_off, a_ri, b_on, b_off, b_ri;
    logic [7:0] pat [6] = '{8'h08, 8'h04, 8'h0A, 8'h09, 8'h08, 8'h08};
    int         failures = 0;
    int         checked  = 0;
    // Short time unit keeps every pattern at most 128 cycles long
    always #20 clk_i = ~clk_i;
    fbled_top #(.UNIT_CYC(4)) i_fbled_top (.clk_i(clk_i), .srst_i(srst_i),
        .ce_i(1'b1), .mode_cip_i(cip), .slave_state_i(st),
        .err_invalid_cfg_i(cfg), .err_local_i(loc), .err_sync_i(syn),
        .err_app_wdog_i(wd), .cip_configured_i(conf),
        .cip_fault_rec_i(rec), .cip_fault_unrec_i(unr),
        .selftest_busy_i(bsy), .module_status_lamp_green_o(mg),
        .module_status_lamp_red_o(mr), .network_status_lamp_green_o(ng),
        .network_status_lamp_red_o(nr), .eff_state_o(eff),
        .err_code_o(code), .selftest_active_o(tact));
    fbled_lamp_meter u_mod (.clk_i(clk_i), .lamp_i(mg | mr),
        .on_len_o(a_on), .off_len_o(a_off), .rises_o(a_ri));
    fbled_lamp_meter u_net (.clk_i(clk_i), .lamp_i(nr),
        .on_len_o(b_on), .off_len_o(b_off), .rises_o(b_ri));
    // Compare and tally
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic conclude();
        $display("Checks %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Slave run states on the module lamp, then a sync error
    task automatic t_slave();
        logic [7:0] r0;
        cyc(8);
        chk(8'(mg), 8'h00);
        st = 2'h1;
        cyc(3);
        chk(8'(mg), 8'h01);
        cyc(70);
        r0 = a_ri;
        cyc(64);
        chk(a_ri - r0, 8'h02);
        chk(a_on, 8'h10);
        chk(a_off, 8'h10);
        st = 2'h2;
        cyc(200);
        r0 = a_ri;
        cyc(96);
        chk(a_ri - r0, 8'h01);
        chk(a_off, 8'h50);
        chk(a_on, 8'h10);
        st = 2'h3;
        cyc(8);
        chk(8'(mg), 8'h01);
        syn = 1'b1;
        cyc(1);
        syn = 1'b0;
        chk(8'({eff, code}), 8'h0A);
    endtask
    // Error ranking and red patterns on the network lamp
    task automatic t_errors();
        logic [7:0] r0;
        st = 2'h2;
        cfg = 1'b1;
        cyc(70);
        chk(8'({code, b_on[5:0]}), 8'h50);
        chk(b_off, 8'h10);
        loc = 1'b1;
        cyc(200);
        chk(8'(code), 8'h02);
        chk(b_off, 8'h50);
        wd = 1'b1;
        cyc(300);
        r0 = b_ri;
        cyc(128);
        chk(b_ri - r0, 8'h02);
        chk(8'({code, b_on[5:0]}), 8'hD0);
        {cfg, loc, wd} = 3'h0;
        cyc(8);
        chk(8'(nr), 8'h00);
    endtask
    // Module lamp under the CIP bus, then the power-up test
    task automatic t_cip();
        cip = 1'b1;
        cyc(8);
        chk(8'({mg, mr, ng, nr}), 8'h08);
        conf = 1'b0;
        cyc(140);
        chk(8'({mr, a_on[6:0]}), 8'h28);
        chk(a_off, 8'h28);
        rec = 1'b1;
        cyc(100);
        chk(8'({mg, a_on[6:0]}), 8'h28);
        unr = 1'b1;
        cyc(8);
        chk(8'({mg, mr}), 8'h01);
        {conf, rec, unr, bsy} = 4'h9;
        for (int i = 0; i < 6; i++) begin
            cyc(i == 0 ? 10 : 20);
            chk(8'({mg, mr, ng, nr}), pat[i]);
        end
        chk(8'(tact), 8'h01);
        bsy = 1'b0;
    endtask
    // Main sequence after a 16-cycle reset
    initial begin
        cyc(16);
        srst_i = 1'b0;
        t_slave();
        t_errors();
        t_cip();
        conclude();
    end
    // Run needs about 1,540 cycles; cut it at 50,000
    initial begin
        #2000000;
        failures++;
        conclude();
    end
endmodule
